// File: csi_top.sv
// Clocked serial interface: 8-bit shift engine, registers, ready pin.
// Assumes sync clock pin input already synchronous to REF_CLK_I.
// Assumes one strobe per cycle and data access only while idle.
// Functional notes
// - Sample-edge bit picks sync clock edge capturing input, per polarity.
// - Output bits launch on a fixed edge, not configurable.
// - Bit order bit: 1 MSB first, 0 LSB first; resets to 0.
// - Writing 1 to trigger starts the clock; writing 0 does nothing.
// - A data register access arms the engine; trigger needs it.
// - Trigger reads 1 until eight pulses done, then 0; resets 0.
// - Data register bits drive the serial output high or low.
// - Sampled input bits assemble into data registers; undefined at reset.
// - Interrupt mask enables request when 1; readable, resets 0.
// - Flag sets on each completed 8-bit transfer regardless of mask.
// - Writing 1 clears the flag; writing 0 leaves it.
// - Request stays high while flag set and mask enabled.
// - Source field: 11 low osc, 10 low/2, 01 timer, 00 slave.
// - Pin enable maps pins; ready used only in slave; resets 0.
// - Slave ready active after trigger; drops on first pulse or high access.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ns
`include "csi_cfg.svh"

module csi_top
    import csi_pkg::*;
#(
    parameter bit POS_POLARITY = 1'b0,
    parameter bit RDY_ACT_HIGH = 1'b0
)
(
    // Clock and reset
    input  wire logic        REF_CLK_I,
    input  wire logic        RSTN_I,
    // Register port
    input  wire logic [15:0] ADDR_I,
    input  wire logic [3:0]  WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic [3:0]       RDATA_O,
    // Clock source ticks
    input  wire logic        LOW_TICK_I,
    input  wire logic        TMR_TICK_I,
    // Serial pins
    input  wire logic        SIN_I,
    output logic             SERIAL_OUTPUT_PIN_O,
    output logic             SERIAL_OUTPUT_PIN_OE_O,
    input  wire logic        SCLK_I,
    output logic             SCLK_O,
    output logic             SCLK_OE_O,
    output logic             SLAVE_READY_PIN_O,
    output logic             SLAVE_READY_PIN_OE_O,
    // Interrupt request and pin function
    output logic             IRQ_O,
    output logic             PIN_EN_O
);
    csi_state_t state_r;
    logic [7:0] shift_r;
    logic [3:0] cnt_r;
    logic [3:0] rdata_nxt;
    logic       pin_en_r;
    logic [1:0] src_r;
    logic       edge_r;
    logic       order_r;
    logic       mask_r;
    logic       flag_r;
    logic       rdy_r;
    logic       sclk_r;
    logic       sclk_in_r;
    logic       serial_output_pin_r;
    logic       half;
    logic       slave;
    logic       wr_ctrl;
    logic       wr_mode;
    logic       wr_lo;
    logic       wr_hi;
    logic       rd_lo;
    logic       rd_hi;
    logic       wr_flag;
    logic       wr_mask;
    logic       trig;
    logic       lvl;
    logic       tog;
    logic       m_rise;
    logic       m_fall;
    logic       s_rise;
    logic       s_fall;
    logic       busy;
    logic       step;
    logic       data_acc;
    logic       rdy_clr;
    logic       flag_clr;
    logic [7:0] shift_nxt;
    logic [7:0] msb_in;
    logic [7:0] lsb_in;
    logic       rise;
    logic       fall;
    logic       launch_edge;
    logic       sample_edge;
    logic       done;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    assign slave   = (src_r == `CSI_SRC_SLAVE);
    assign wr_ctrl = WR_I && (ADDR_I == `CSI_OFS_CTRL);
    assign wr_mode = WR_I && (ADDR_I == `CSI_OFS_MODE);
    assign wr_lo   = WR_I && (ADDR_I == `CSI_OFS_DATA_LO);
    assign wr_hi   = WR_I && (ADDR_I == `CSI_OFS_DATA_HI);
    assign rd_lo   = RD_I && (ADDR_I == `CSI_OFS_DATA_LO);
    assign rd_hi   = RD_I && (ADDR_I == `CSI_OFS_DATA_HI);
    assign wr_flag = WR_I && (ADDR_I == `CSI_OFS_FLAG);
    assign wr_mask = WR_I && (ADDR_I == `CSI_OFS_MASK);
    // Trigger honoured only once armed; a second trigger mid-run is ignored
    assign trig    = wr_ctrl && WDATA_I[`CSI_BIT_TRIG] && (state_r == CSI_ARMED);
    assign busy    = (state_r == CSI_RUN);
    // Reads arm the engine as well as writes
    assign data_acc = wr_lo || wr_hi || rd_lo || rd_hi;

    // ----------------------------------------
    // Clock generation and edge detection
    // ----------------------------------------
    // Divider runs while idle, so its phase at the trigger is arbitrary
    csi_clk_gen u_clk_gen
    (
        .clk_i      (REF_CLK_I),
        .rstn_i     (RSTN_I),
        .src_i      (src_r),
        .low_tick_i (LOW_TICK_I),
        .tmr_tick_i (TMR_TICK_I),
        .half_o     (half)
    );

    // ----------------------------------------
    // Edge detection
    // ----------------------------------------
    // Internal level tracks pin level; idle level high for negative polarity
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RSTN_I)
            sclk_in_r <= ~POS_POLARITY;
        else
            sclk_in_r <= SCLK_I;
    end

    // Master edges named by the level the clock moves to at this edge
    assign tog      = half && !(cnt_r == `CSI_BITS && sclk_r == ~POS_POLARITY);
    assign m_rise   = tog && !sclk_r;
    assign m_fall   = tog && sclk_r;
    // Slave edges seen in the same cycle the pin level changes; harmless at the 1 MHz limit
    assign s_rise   = SCLK_I && !sclk_in_r;
    assign s_fall   = !SCLK_I && sclk_in_r;
    assign lvl      = slave ? SCLK_I : sclk_r;
    assign rise     = busy && (slave ? s_rise : m_rise);
    assign fall     = busy && (slave ? s_fall : m_fall);
    // Launch on the leading edge out of idle: falling when idle high
    assign launch_edge = POS_POLARITY ? rise : fall;
    // Edge select bit meaning flips with polarity
    assign sample_edge = (edge_r ^ POS_POLARITY) ? fall : rise;
    assign done        = (cnt_r == `CSI_BITS) && (lvl == ~POS_POLARITY) && busy;

    // Master clock toggles each half period, exactly eight pulses
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RSTN_I)
            sclk_r <= ~POS_POLARITY;
        else if (state_r != CSI_RUN || slave)
            sclk_r <= ~POS_POLARITY;
        else if (tog)
            sclk_r <= ~sclk_r;
    end

    // ----------------------------------------
    // Engine state
    // ----------------------------------------
    // Run ends only once the clock is back at its idle level
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RSTN_I)
            state_r <= CSI_IDLE;
        else
        begin
            case (state_r)
                CSI_IDLE:
                    if (data_acc)
                        state_r <= CSI_ARMED;
                CSI_ARMED:
                    if (trig)
                        state_r <= CSI_RUN;
                CSI_RUN:
                    if (done)
                        state_r <= CSI_IDLE;
                default:
                    state_r <= CSI_IDLE;
            endcase
        end
    end

    // Count sample edges; the first bit sits on the pin before the first edge
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RSTN_I)
            cnt_r <= 4'h0;
        else if (trig)
            cnt_r <= 4'h0;
        else if (step)
            cnt_r <= cnt_r + 4'h1;
    end

    // ----------------------------------------
    // Shift data
    // ----------------------------------------
    // Bit order picks which end is the head; one chain serves both ways
    assign step   = sample_edge && (cnt_r != `CSI_BITS);
    assign msb_in = {shift_r[6:0], SIN_I};
    assign lsb_in = {SIN_I, shift_r[7:1]};
    for (genvar b = 0; b < 8; b++)
    begin : g_shift
        // Nibble write beats a shift; software must not write mid-run anyway
        assign shift_nxt[b] = ((b < 4) ? wr_lo : wr_hi) ? WDATA_I[b % 4]
                            : (step ? (order_r ? msb_in[b] : lsb_in[b]) : shift_r[b]);
    end
    // No reset: contents undefined until loaded or received
    always_ff @(posedge REF_CLK_I)
    begin
        shift_r <= shift_nxt;
    end

    // Output follows current head bit, updated on launch edges and at start
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RSTN_I)
            serial_output_pin_r <= 1'b0;
        else if (trig || launch_edge)
            serial_output_pin_r <= order_r ? shift_r[7] : shift_r[0];
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RSTN_I)
            pin_en_r <= `CSI_RST_BIT;
        else if (wr_ctrl)
            pin_en_r <= WDATA_I[`CSI_BIT_PIN_EN];
    end

    always_ff @(posedge REF_CLK_I)
    begin
        if (!RSTN_I)
        begin
            src_r   <= `CSI_RST_SRC;
            edge_r  <= `CSI_RST_BIT;
            order_r <= `CSI_RST_BIT;
        end
        else if (wr_mode)
        begin
            src_r   <= WDATA_I[`CSI_BIT_SRC_HI:`CSI_BIT_SRC_LO];
            edge_r  <= WDATA_I[`CSI_BIT_EDGE];
            order_r <= WDATA_I[`CSI_BIT_ORDER];
        end
    end

    always_ff @(posedge REF_CLK_I)
    begin
        if (!RSTN_I)
            mask_r <= `CSI_RST_BIT;
        else if (wr_mask)
            mask_r <= WDATA_I[`CSI_BIT_IRQ];
    end

    // Clear needs a one in the flag bit
    assign flag_clr = wr_flag && WDATA_I[`CSI_BIT_IRQ];
    // Completion beats a same-cycle clear
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RSTN_I)
            flag_r <= `CSI_RST_BIT;
        else if (done)
            flag_r <= 1'b1;
        else if (flag_clr)
            flag_r <= 1'b0;
    end

    // Either edge kind counts as the first pulse
    assign rdy_clr = launch_edge || sample_edge || wr_hi || rd_hi;
    // Ready: set by trigger, dropped on first pulse or high nibble access
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RSTN_I)
            rdy_r <= 1'b0;
        else if (trig && slave)
            rdy_r <= 1'b1;
        else if (rdy_clr)
            rdy_r <= 1'b0;
    end

    // ----------------------------------------
    // Read back
    // ----------------------------------------
    // Reads change no status bit except ready, which a high data read drops; only data reads arm the engine
    always_comb
    begin
        rdata_nxt = 4'h0;
        case (ADDR_I)
            `CSI_OFS_CTRL:    rdata_nxt = {2'h0, busy, pin_en_r};
            `CSI_OFS_MODE:    rdata_nxt = {order_r, edge_r, src_r};
            `CSI_OFS_DATA_LO: rdata_nxt = shift_r[3:0];
            `CSI_OFS_DATA_HI: rdata_nxt = shift_r[7:4];
            `CSI_OFS_MASK:    rdata_nxt = {3'h0, mask_r};
            `CSI_OFS_FLAG:    rdata_nxt = {3'h0, flag_r};
            default:          rdata_nxt = 4'h0;
        endcase
    end

    always_ff @(posedge REF_CLK_I)
    begin
        if (!RSTN_I)
            RDATA_O <= 4'h0;
        else if (RD_I)
            RDATA_O <= rdata_nxt;
    end

    // ----------------------------------------
    // Pins
    // ----------------------------------------
    assign SERIAL_OUTPUT_PIN_O    = serial_output_pin_r;
    assign SERIAL_OUTPUT_PIN_OE_O = pin_en_r;
    assign SCLK_O    = sclk_r;
    assign SCLK_OE_O = pin_en_r && !slave;
    // Ready level flips with the build option
    assign SLAVE_READY_PIN_O    = RDY_ACT_HIGH ? rdy_r : ~rdy_r;
    assign SLAVE_READY_PIN_OE_O = pin_en_r && slave;
    assign IRQ_O     = flag_r && mask_r;
    assign PIN_EN_O  = pin_en_r;
endmodule

// File: csi_cfg.svh
// Constants for the clocked serial interface: offsets, fields, resets.
// Assumes inclusion by bare name from package and modules.
`ifndef CSI_CFG_SVH
`define CSI_CFG_SVH
// ----------------------------------------
// Register offsets (16-bit I/O addresses)
// ----------------------------------------
`define CSI_OFS_CTRL      16'hFF70
`define CSI_OFS_MODE      16'hFF71
`define CSI_OFS_DATA_LO   16'hFF72
`define CSI_OFS_DATA_HI   16'hFF73
`define CSI_OFS_MASK      16'hFFE3
`define CSI_OFS_FLAG      16'hFFF3
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CSI_BIT_PIN_EN    0
`define CSI_BIT_TRIG      1
`define CSI_BIT_SRC_LO    0
`define CSI_BIT_SRC_HI    1
`define CSI_BIT_EDGE      2
`define CSI_BIT_ORDER     3
`define CSI_BIT_IRQ       0
// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define CSI_RST_SRC       2'h0
`define CSI_RST_BIT       1'h0
`define CSI_BITS          4'h8
`define CSI_SRC_SLAVE     2'h0
`define CSI_SRC_TIMER     2'h1
`define CSI_SRC_LOW_DIV2  2'h2
`define CSI_SRC_LOW       2'h3
`endif

// File: csi_pkg.sv
// Types for the clocked serial interface.
// Assumes csi_cfg.svh is on the include path.
`include "csi_cfg.svh"
package csi_pkg;
    typedef enum logic [1:0]
    {
        CSI_IDLE  = 2'b00,
        CSI_ARMED = 2'b01,
        CSI_RUN   = 2'b10
    } csi_state_t;
    typedef logic [1:0] csi_src_t;
endpackage

// File: csi_clk_gen.sv
// Master clock enable generator for the serial interface.
// Assumes one-cycle tick inputs from the oscillator and timer domains.
`timescale 1ns/1ns
`include "csi_cfg.svh"
module csi_clk_gen
    import csi_pkg::*;
(
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rstn_i,
    // Control
    input  wire csi_pkg::csi_src_t src_i,
    input  wire logic         low_tick_i,
    input  wire logic         tmr_tick_i,
    // Half-period pulse
    output logic              half_o
);
    logic div_r;
    logic raw;
    // ----------------------------------------
    // Source select and divide by two
    // ----------------------------------------
    always_comb
    begin
        case (src_i)
            `CSI_SRC_LOW:      raw = low_tick_i;
            `CSI_SRC_LOW_DIV2: raw = low_tick_i;
            `CSI_SRC_TIMER:    raw = tmr_tick_i;
            default:           raw = 1'b0;
        endcase
    end
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            div_r <= 1'b0;
        else if (raw)
            div_r <= ~div_r;
    end
    // Low osc and timer underflow: one tick per half period; halved low osc: every second tick
    assign half_o = (src_i == `CSI_SRC_LOW_DIV2) ? (raw & div_r) : raw;
endmodule

// File: csi_top_chk.sv
// Port checker for csi_top.
// Assumes a bind onto csi_top; one clock, sync active-low reset.
`timescale 1ns/1ns
module csi_top_chk #(
    parameter bit POS_POLARITY = 1'b0,
    parameter bit RDY_ACT_HIGH = 1'b0
)
(
    // Clock, reset, register port
    input wire logic        REF_CLK_I,
    input wire logic        RSTN_I,
    input wire logic [15:0] ADDR_I,
    input wire logic [3:0]  WDATA_I,
    input wire logic        WR_I,
    input wire logic        RD_I,
    // Pins
    input wire logic        SERIAL_OUTPUT_PIN_O,
    input wire logic        SERIAL_OUTPUT_PIN_OE_O,
    input wire logic        SCLK_O,
    input wire logic        SCLK_OE_O,
    input wire logic        SLAVE_READY_PIN_O,
    input wire logic        SLAVE_READY_PIN_OE_O,
    input wire logic        IRQ_O,
    input wire logic        PIN_EN_O
);
    logic [3:0] fall_cnt_r;
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RSTN_I);
    // Saturating, so a ninth pulse still shows
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RSTN_I || (WR_I && ADDR_I == 16'hFF70 && WDATA_I[1]))
            fall_cnt_r <= 4'h0;
        else if (SCLK_OE_O && $fell(SCLK_O) && fall_cnt_r != 4'hF)
            fall_cnt_r <= fall_cnt_r + 4'h1;
    end
    // ----
    // Assertions
    // ----
    pin_en_a: assert property (WR_I && ADDR_I == 16'hFF70 |=> PIN_EN_O == $past(WDATA_I[0]))
        else $error("pin enable wrong");
    oe_map_a: assert property (SERIAL_OUTPUT_PIN_OE_O == PIN_EN_O)
        else $error("output enable wrong");
    oe_split_a: assert property (SCLK_OE_O |-> PIN_EN_O && !SLAVE_READY_PIN_OE_O)
        else $error("clock and ready enables clash");
    rdy_drop_a: assert property ((WR_I || RD_I) && ADDR_I == 16'hFF73 && SLAVE_READY_PIN_OE_O
        |=> SLAVE_READY_PIN_O == !RDY_ACT_HIGH)
        else $error("ready kept after high access");
    irq_mask_a: assert property (WR_I && ADDR_I == 16'hFFE3 && !WDATA_I[0] |=> !IRQ_O)
        else $error("masked request seen");
    irq_hold_a: assert property (IRQ_O && !(WR_I && ADDR_I inside {16'hFFE3, 16'hFFF3})
        |=> IRQ_O)
        else $error("request dropped");
    pulse_cnt_a: assert property (fall_cnt_r <= 4'h8)
        else $error("too many clock pulses");
    serial_output_pin_launch_a: assert property ((POS_POLARITY ? $fell(SCLK_O) : $rose(SCLK_O)) && SCLK_OE_O
        |-> $stable(SERIAL_OUTPUT_PIN_O))
        else $error("output moved on wrong edge");
    cover property (fall_cnt_r == 4'h8);
    cover property (IRQ_O);
    cover property (SLAVE_READY_PIN_OE_O && SLAVE_READY_PIN_O == RDY_ACT_HIGH);
endmodule

bind csi_top csi_top_chk #(.POS_POLARITY(POS_POLARITY), .RDY_ACT_HIGH(RDY_ACT_HIGH)) u_chk (
    .REF_CLK_I(REF_CLK_I), .RSTN_I(RSTN_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
    .WR_I(WR_I), .RD_I(RD_I), .SERIAL_OUTPUT_PIN_O(SERIAL_OUTPUT_PIN_O), .SERIAL_OUTPUT_PIN_OE_O(SERIAL_OUTPUT_PIN_OE_O), .SCLK_O(SCLK_O),
    .SCLK_OE_O(SCLK_OE_O), .SLAVE_READY_PIN_O(SLAVE_READY_PIN_O), .SLAVE_READY_PIN_OE_O(SLAVE_READY_PIN_OE_O), .IRQ_O(IRQ_O),
    .PIN_EN_O(PIN_EN_O)
);

// File: csi_peer.sv
// Far-side serial peer: clock master in slave mode, shift partner always.
// Assumes negative polarity and the bench reference clock.
`timescale 1ns/1ns
module csi_peer #(
    parameter int HALF = 64
)
(
    // Control
    input  wire logic       clk_i,
    input  wire logic       go_i,
    input  wire logic       clk_go_i,
    input  wire logic       msb_i,
    input  wire logic       fall_smp_i,
    input  wire logic [7:0] tx_i,
    // Wire side
    input  wire logic       sclk_i,
    input  wire logic       serial_output_pin_i,
    output logic            sclk_o,
    output logic            sin_o,
    output logic [7:0]      rx_o
);
    logic [2:0] d_r    = 3'h7;
    logic [3:0] k_r    = 4'h8;
    logic [3:0] j_r    = 4'h8;
    logic       seen_r = 1'b0;
    int         cnt_r  = 0;
    function automatic logic [2:0] pos(input logic [3:0] n);
        return msb_i ? 3'h7 - n[2:0] : n[2:0];
    endfunction
    // ----
    // Model
    // ----
    // Eight pulses, idle high; started only by the bench after a trigger
    assign sclk_o = cnt_r == 0 || ((cnt_r - 1) / HALF) % 2 == 0;
    // Pull-up level outside frames
    assign sin_o = (k_r[3] || j_r[3]) ? 1'b1 : tx_i[pos(k_r)];
    always @(posedge clk_i)
    begin
        d_r <= {d_r[1:0], sclk_i};
        if (clk_go_i)
            cnt_r <= 16 * HALF;
        else if (cnt_r != 0)
            cnt_r <= cnt_r - 1;
        if (go_i)
        begin
            k_r <= 4'h0;
            j_r <= 4'h0;
            seen_r <= 1'b0;
        end
        else if (d_r[1] != d_r[2])
        begin
            // Advance only after a sample, two cycles clear of the edge
            if (d_r[1] != fall_smp_i)
                seen_r <= 1'b1;
            else if (seen_r)
            begin
                k_r <= k_r + 4'h1;
                seen_r <= 1'b0;
            end
            if (d_r[1] && !j_r[3])
            begin
                rx_o[pos(j_r)] <= serial_output_pin_i;
                j_r <= j_r + 4'h1;
            end
        end
    end
endmodule

// File: csi_top_bench.sv
// Bench for csi_top: register tasks, master and slave transfers.
// Assumes csi_peer on the serial pins and the bound checker.
`timescale 1ns/1ns
module csi_top_bench;
    import csi_pkg::*;
    logic        clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, go = 1'b0, clk_go = 1'b0;
    logic        low_tick = 1'b0, tmr_tick = 1'b0, msb = 1'b0, fall_smp = 1'b0, slv;
    logic [15:0] addr = 16'h0000;
    logic [3:0]  wdata = 4'h0, rdata, v;
    logic [7:0]  tx = 8'h00, rx;
    logic [5:0]  tick_r = 6'h00;
    logic        serial_input_pin, serial_output_pin, serial_output_pin_oe, sclk_o, sclk_oe, peer_sclk, sclk_w, slave_ready_pin, slave_ready_pin_oe, irq, pin_en;
    logic [3:0]  mode_tab [4] = '{4'h3, 4'hE, 4'h5, 4'h8};
    logic [7:0]  dat_tab [4] = '{8'hA5, 8'h3C, 8'h81, 8'h7E};
    logic [7:0]  pat_tab [4] = '{8'h5A, 8'hC1, 8'h18, 8'hE4};
    int          n_errors = 0;
    int          check_count = 0;
    assign sclk_w = sclk_oe ? sclk_o : peer_sclk;
    always #4 clk = ~clk;
    always @(posedge clk)
    begin
        tick_r <= tick_r + 6'h01;
        low_tick <= tick_r[3:0] == 4'hF;
        tmr_tick <= tick_r[2:0] == 3'h3;
    end
    csi_top u_dut (
        .REF_CLK_I(clk), .RSTN_I(rstn), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .LOW_TICK_I(low_tick), .TMR_TICK_I(tmr_tick), .SIN_I(serial_input_pin),
        .SERIAL_OUTPUT_PIN_O(serial_output_pin), .SERIAL_OUTPUT_PIN_OE_O(serial_output_pin_oe), .SCLK_I(sclk_w), .SCLK_O(sclk_o),
        .SCLK_OE_O(sclk_oe), .SLAVE_READY_PIN_O(slave_ready_pin), .SLAVE_READY_PIN_OE_O(slave_ready_pin_oe), .IRQ_O(irq), .PIN_EN_O(pin_en)
    );
    csi_peer u_peer (
        .clk_i(clk), .go_i(go), .clk_go_i(clk_go), .msb_i(msb), .fall_smp_i(fall_smp),
        .tx_i(tx), .sclk_i(sclk_w), .serial_output_pin_i(serial_output_pin), .sclk_o(peer_sclk), .sin_o(serial_input_pin), .rx_o(rx)
    );
    // ----
    // Tasks
    // ----
    task automatic check(input string w, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", w, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [3:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Data appear in the cycle after the strobe and hold until the next read
    task automatic rd_reg(input logic [15:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic rchk(input string w, input logic [15:0] a, input logic [3:0] e);
        rd_reg(a);
        check(w, v, e);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        #400000;
        n_errors++;
        tally_and_finish();
    end
    // ----
    // Tests
    // ----
    initial
    begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        rchk("ctrl", 16'hFF70, 4'h0);
        rchk("mode", 16'hFF71, 4'h0);
        rchk("mask", 16'hFFE3, 4'h0);
        rchk("flag", 16'hFFF3, 4'h0);
        rchk("unmapped", 16'hFF74, 4'h0);
        wr_reg(16'hFF70, 4'h3);
        rchk("unarmed", 16'hFF70, 4'h1);
        $display("test reset done");
        for (int i = 0; i < 4; i++)
        begin
            slv = mode_tab[i][1:0] == 2'h0;
            msb <= mode_tab[i][3];
            fall_smp <= mode_tab[i][2];
            tx <= pat_tab[i];
            go <= 1'b1;
            wr_reg(16'hFF71, mode_tab[i]);
            wr_reg(16'hFFE3, {3'h0, i[0]});
            wr_reg(16'hFF70, 4'h1);
            wr_reg(16'hFF72, dat_tab[i][3:0]);
            wr_reg(16'hFF73, dat_tab[i][7:4]);
            wr_reg(16'hFF70, 4'h3);
            go <= 1'b0;
            rchk("run", 16'hFF70, 4'h3);
            if (slv)
            begin
                check("ready on", {slave_ready_pin_oe, slave_ready_pin}, 8'h02);
                clk_go <= 1'b1;
                @(posedge clk);
                clk_go <= 1'b0;
            end
            // Poll without comparing; the stop read below checks the outcome
            for (int n = 0; n < 1000 && v[1] !== 1'b0; n++)
                rd_reg(16'hFF70);
            rchk("stop", 16'hFF70, 4'h1);
            check("enables", {sclk_oe, slave_ready_pin_oe}, {6'h00, !slv, slv});
            check("ready off", slave_ready_pin | !slv, 8'h01);
            check("sent", rx, dat_tab[i]);
            rchk("recv lo", 16'hFF72, pat_tab[i][3:0]);
            rchk("recv hi", 16'hFF73, pat_tab[i][7:4]);
            rchk("mode", 16'hFF71, mode_tab[i]);
            rchk("mask", 16'hFFE3, {3'h0, i[0]});
            rchk("flag", 16'hFFF3, 4'h1);
            check("irq", irq, i[0]);
            wr_reg(16'hFFF3, 4'h0);
            rchk("flag kept", 16'hFFF3, 4'h1);
            wr_reg(16'hFFF3, 4'h1);
            rchk("flag clear", 16'hFFF3, 4'h0);
            check("irq off", irq, 8'h00);
            wr_reg(16'hFF70, 4'h1);
            rchk("no start", 16'hFF70, 4'h1);
            $display("test case %0d done", i);
        end
        tally_and_finish();
    end
endmodule
